/* testbench/core_model.sv */
// Core model: issues sleep and watchdog-clear instructions
module core_model
   import wdt_sleep_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        run_i,
   input  wire logic        do_sleep_i,
   input  wire logic        do_clear_i,
   output logic             sleep_o,
   output logic             clear_o,
   output logic      [15:0] pc_o,
   output logic      [7:0]  io_out_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Instructions issue only while the core runs
   always_ff @(posedge clk_i) begin
      sleep_o <= resetn_i & run_i & do_sleep_i;
      clear_o <= resetn_i & run_i & do_clear_i;
   end

   // PC halts with the core; pins keep moving so a freeze shows
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pc_o     <= 16'h0100;
         io_out_o <= 8'h00;
      end else begin
         if (run_i) begin
            pc_o <= pc_o + 16'h0001;
         end
         io_out_o <= io_out_o + 8'h01;
      end
   end
endmodule : core_model

/* testbench/wdt_sleep_ctrl_tb_top.sv */
// Self-checking testbench for the watchdog and sleep controller
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, a); end end
module wdt_sleep_ctrl_tb_top import wdt_sleep_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // Short counts keep the run brief
   localparam int WC = 20;
   localparam int OC = 4;
   logic        core_clk, resetn, master_clear_pin_n_n, global_irq_enable, do_sleep, do_clear, sleep_i, clear_i;
   logic [7:0]  fuses, io_in, io_out_o, reg_rdata_o, hold, oe;
   logic [15:0] pc, p, q, vpc, fetch_addr_o, push_pc_o;
   logic        device_reset_o, core_run_o, osc_drive_en_o, prefetch_o, vector_o;
   logic        stack_push_o, periph_irq_gate_o, master_clear_pin_n_drive_oe_n_o, vpush;
   irq_vec_t    iflag, ien;
   reg_req_t    req;
   int          failures, checks_done, bad_rst, vec_n, n;

   wdt_sleep_ctrl #(.WDT_CYCLES(WC), .OST_CYCLES(OC)) u_wdt_sleep_ctrl (
      .core_clk_i(core_clk), .resetn_i(resetn), .master_clear_pin_n_pin_n_i(master_clear_pin_n_n), .sleep_instr_i(sleep_i),
      .watchdog_clear_instr_i(clear_i), .config_fuses_i(fuses), .global_irq_enable_i(global_irq_enable),
      .irq_flag_i(iflag), .irq_enable_i(ien), .pc_i(pc), .io_out_i(io_in), .io_oe_n_i(8'h0f),
      .reg_req_i(req), .reg_rdata_o(reg_rdata_o), .device_reset_o(device_reset_o),
      .core_run_o(core_run_o), .osc_drive_en_o(osc_drive_en_o), .prefetch_o(prefetch_o),
      .fetch_addr_o(fetch_addr_o), .vector_o(vector_o), .stack_push_o(stack_push_o),
      .push_pc_o(push_pc_o), .periph_irq_gate_o(periph_irq_gate_o), .io_out_o(io_out_o),
      .io_oe_n_o(oe), .master_clear_pin_n_drive_oe_n_o(master_clear_pin_n_drive_oe_n_o));

   core_model u_core_model (
      .clk_i(core_clk), .resetn_i(resetn), .run_i(core_run_o), .do_sleep_i(do_sleep),
      .do_clear_i(do_clear), .sleep_o(sleep_i), .clear_o(clear_i), .pc_o(pc), .io_out_o(io_in));

   always #50 core_clk = ~core_clk;

   // Vector pulses are one cycle wide, so latch them as they pass
   always @(posedge core_clk) begin
      if (vector_o === 1'b1) begin
         vec_n++;
         vpc = push_pc_o;
         vpush = stack_push_o;
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge core_clk);
      req <= '0;
   endtask : wr

   task automatic rd(input string s, input logic [13:0] a, input logic [7:0] e);
      @(posedge core_clk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      req <= '0;
      #1;
      `CHK(s, e, reg_rdata_o)
   endtask : rd

   task automatic kick;
      @(posedge core_clk);
      do_clear <= 1'b1;
      @(posedge core_clk);
      do_clear <= 1'b0;
   endtask : kick

   task automatic setup(input logic [7:0] f, input logic [7:0] o);
      @(posedge core_clk);
      fuses <= f;
      wr(OPTION_IDX, o);
      kick;
   endtask : setup

   task automatic sleep_go;
      @(posedge core_clk);
      do_sleep <= 1'b1;
      @(posedge core_clk);
      do_sleep <= 1'b0;
      #1;
      p = pc;
      tick(1);
   endtask : sleep_go

   // Bounded wait: 0 device reset, 1 core running
   task automatic wait_on(input int k, input int lim);
      n = 0;
      while ((k == 0 ? device_reset_o : core_run_o) !== 1'b1 && n < lim) begin
         tick(1);
         n++;
         if (k != 0 && device_reset_o === 1'b1) bad_rst++;
      end
   endtask : wait_on

   task automatic quiet(input int k);
      repeat (k) begin
         tick(1);
         if (device_reset_o !== 1'b0) bad_rst++;
      end
   endtask : quiet

   task automatic t_regs;
      rd("option", OPTION_IDX, OPTION_RST);
      rd("status", STATUS_IDX, STATUS_RST);
      rd("config", CONFIG_IDX, 8'h03);
      rd("unmapped", 14'h0055, 8'h00);
      wr(OPTION_IDX, 8'h5a);
      wr(STATUS_IDX, 8'h00);
      rd("option wr", OPTION_IDX, 8'h5a);
      rd("status ro", STATUS_IDX, STATUS_RST);
   endtask : t_regs

   // Unscaled period, then rates 0..2 through the prescaler
   task automatic t_expiry;
      for (int r = -1; r < 3; r++) begin
         setup(8'h04, r < 0 ? 8'h00 : 8'h08 | 8'(r));
         wait_on(0, 120);
         `CHK("period", 1'b1, n inside {[(WC << (r < 0 ? 0 : r)) - 3 : (WC << (r < 0 ? 0 : r)) + 4]})
         `CHK("master_clear_pin_n oe_n", 1'b1, master_clear_pin_n_drive_oe_n_o)
         rd("to after wdt", STATUS_IDX, 8'h08);
         rd("opt after wdt", OPTION_IDX, 8'hff);
      end
   endtask : t_expiry

   task automatic t_kick;
      bad_rst = 0;
      setup(8'h04, 8'h00);
      repeat (4) begin
         kick;
         quiet(14);
      end
      `CHK("kicked", 0, bad_rst)
      setup(8'h03, 8'h00);
      quiet(100);
      `CHK("fuse off", 0, bad_rst)
   endtask : t_kick

   task automatic t_wdt_wake;
      bad_rst = 0;
      setup(8'h04, 8'h00);
      sleep_go;
      hold = io_out_o;
      `CHK("run", 1'b0, core_run_o)
      `CHK("osc", 1'b0, osc_drive_en_o)
      `CHK("prefetch", 1'b1, prefetch_o)
      `CHK("fetch", p + 16'h0001, fetch_addr_o)
      `CHK("gate", 1'b0, periph_irq_gate_o)
      tick(10);
      `CHK("io hold", hold, io_out_o)
      `CHK("oe hold", 8'h0f, oe)
      wait_on(1, 40);
      `CHK("wake time", 1'b1, n + 10 inside {[WC + OC - 3 : WC + OC + 4]})
      `CHK("no reset", 0, bad_rst)
      rd("wdt wake", STATUS_IDX, 8'h00);
   endtask : t_wdt_wake

   // Timer flag must not wake; pin flag wakes, vector only with global enable
   task automatic t_irq(input logic g);
      setup(8'h03, 8'hff);
      vec_n = 0;
      @(posedge core_clk);
      global_irq_enable <= g;
      ien <= irq_vec_t'(4'h9);
      sleep_go;
      q = pc;
      @(posedge core_clk);
      iflag <= irq_vec_t'(4'h1);
      tick(4);
      `CHK("timer wake", 1'b0, core_run_o)
      @(posedge core_clk);
      iflag <= irq_vec_t'(4'h9);
      wait_on(1, 8);
      `CHK("rc wake", 1'b1, n <= 3)
      tick(3);
      `CHK("vectors", int'(g), vec_n)
      if (g) begin
         `CHK("push", 1'b1, vpush)
         `CHK("ret pc", q + 16'h0001, vpc)
      end
      rd("irq wake", STATUS_IDX, 8'h10);
   endtask : t_irq

   task automatic t_noop;
      kick;
      @(posedge core_clk);
      global_irq_enable <= 1'b0;
      iflag <= irq_vec_t'(4'h8);
      sleep_go;
      tick(2);
      `CHK("noop run", 1'b1, core_run_o)
      rd("noop flags", STATUS_IDX, 8'h18);
      @(posedge core_clk);
      iflag <= '0;
   endtask : t_noop

   task automatic t_master_clear_pin_n;
      sleep_go;
      tick(3);
      @(posedge core_clk);
      master_clear_pin_n_n <= 1'b0;
      wait_on(0, 8);
      `CHK("master_clear_pin_n reset", 1'b1, device_reset_o)
      `CHK("master_clear_pin_n oe_n", 1'b1, master_clear_pin_n_drive_oe_n_o)
      @(posedge core_clk);
      master_clear_pin_n_n <= 1'b1;
      wait_on(1, 20);
      `CHK("master_clear_pin_n wake", 1'b1, core_run_o)
   endtask : t_master_clear_pin_n

   task automatic final_report;
      $display("Checks %0d, errors %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #3_000_000;
      failures++;
      final_report;
   end

   initial begin
      core_clk = 1'b0;
      resetn = 1'b0;
      master_clear_pin_n_n = 1'b1;
      fuses = 8'h03;
      global_irq_enable = 1'b0;
      iflag = '0;
      ien = '0;
      req = '0;
      do_sleep = 1'b0;
      do_clear = 1'b0;
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs;
      t_expiry;
      t_kick;
      t_wdt_wake;
      t_irq(1'b1);
      iflag <= '0;
      t_irq(1'b0);
      iflag <= '0;
      t_noop;
      t_master_clear_pin_n;
      final_report;
   end
endmodule : wdt_sleep_ctrl_tb_top

/* verilog/wdt_sleep_ctrl.sv */
// Watchdog timer, prescaler and power-down controller
//
// Behaviour
// - Interrupt entry pushes only return PC
// - Watchdog runs from its own free clock
// - Expiry while running gives device reset
// - Expiry while asleep wakes, no reset
// - Fuse zero disables watchdog forever
// - Base time-out is eighteen milliseconds
// - Option register assigns prescaler, up to 128
// - Clear or sleep resets counter and prescaler
// - Expiry clears time-out flag
// - Sleep clears watchdog, pd low, to high
// - Pins hold drive state while asleep
// - Watchdog reset never drives master clear
// - Wake on clear, watchdog, pin, port-change or EEPROM-done interrupts
// - Clock-bound peripherals silent while asleep
// - Master clear wake resets, others continue
// - Sleep prefetches the next instruction
// - Wake needs individual enable only
// - Global enable decides vector after wake
// - Pending enabled interrupt makes sleep a no-op
// - Interrupt during sleep: finish, then wake
// - Start-up delay after watchdog or interrupt wake unless RC
module wdt_sleep_ctrl
   import wdt_sleep_pkg::*;
#(
   parameter int unsigned WDT_CYCLES = WDT_BASE_CYC,
   parameter int unsigned OST_CYCLES = OST_OSC_PERIODS
) (
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        master_clear_pin_n_pin_n_i,
   input  wire logic        sleep_instr_i,
   input  wire logic        watchdog_clear_instr_i,
   input  wire logic [7:0]  config_fuses_i,
   input  wire logic        global_irq_enable_i,
   input  wire irq_vec_t    irq_flag_i,
   input  wire irq_vec_t    irq_enable_i,
   input  wire logic [15:0] pc_i,
   input  wire logic [7:0]  io_out_i,
   input  wire logic [7:0]  io_oe_n_i,
   input  wire reg_req_t    reg_req_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             device_reset_o,
   output logic             core_run_o,
   output logic             osc_drive_en_o,
   output logic             prefetch_o,
   output logic      [15:0] fetch_addr_o,
   output logic             vector_o,
   output logic             stack_push_o,
   output logic      [15:0] push_pc_o,
   output logic             periph_irq_gate_o,
   output logic      [7:0]  io_out_o,
   output logic      [7:0]  io_oe_n_o,
   output logic             master_clear_pin_n_drive_oe_n_o
);
   localparam int unsigned CW = $clog2(WDT_CYCLES + 1);
   localparam int unsigned OW = $clog2(OST_CYCLES + 1);

   // ------------------------------------------------------------
   // Master clear pin synchroniser
   // ------------------------------------------------------------
   logic [2:0] master_clear_pin_n_sync_ff;
   logic       master_clear_pin_n_n_ff;
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         master_clear_pin_n_sync_ff <= 3'h7;
         master_clear_pin_n_n_ff    <= 1'b1;
      end else begin
         master_clear_pin_n_sync_ff <= {master_clear_pin_n_sync_ff[1:0], master_clear_pin_n_pin_n_i};
         if (master_clear_pin_n_sync_ff[1] == master_clear_pin_n_sync_ff[2])
            master_clear_pin_n_n_ff <= master_clear_pin_n_sync_ff[2];
      end
   end
   wire logic master_clear_pin_n_rst = !master_clear_pin_n_n_ff;

   // ------------------------------------------------------------
   // Registers and decode
   // ------------------------------------------------------------
   logic [7:0] option_control_ff;
   logic       timeout_flag_n_ff;
   logic       powerdown_flag_n_ff;
   pm_state_t  state_ff;
   pm_state_t  nxt_state;

   wire logic wdt_enabled = config_fuses_i[CFG_WATCHDOG_ENABLE_FUSE];
   wire logic prescaler_assign         = option_control_ff[OPT_PSA];
   wire logic [2:0] rate  = option_control_ff[OPT_PS_LO +: 3];
   wire logic is_rc_osc   = (config_fuses_i[1:0] == OSC_RC);

   // Only sources with their own enable count; global enable ignored here
   wire logic irq_pending = |(irq_flag_i & irq_enable_i);
   // Timer overflow cannot wake: its clock is stopped while asleep
   wire logic wake_irq = irq_flag_i.ext_pin && irq_enable_i.ext_pin ||
                         irq_flag_i.port_change && irq_enable_i.port_change ||
                         irq_flag_i.ee_done && irq_enable_i.ee_done;

   wire logic sleep_take = sleep_instr_i && (state_ff == ST_RUN) && !irq_pending;
   wire logic wdt_clear  = watchdog_clear_instr_i || sleep_take;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         option_control_ff <= OPTION_RST;
      end else if (master_clear_pin_n_rst || device_reset_o) begin
         option_control_ff <= OPTION_RST;
      end else if (reg_req_i.wr && reg_req_i.addr == OPTION_IDX) begin
         option_control_ff <= reg_req_i.wdata;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            OPTION_IDX: reg_rdata_o <= option_control_ff;
            CONFIG_IDX: reg_rdata_o <= config_fuses_i;
            STATUS_IDX: reg_rdata_o <= {3'h0, timeout_flag_n_ff, powerdown_flag_n_ff, 3'h0};
            default:    reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Watchdog: prescaler and base counter
   // ------------------------------------------------------------
   // Free-running on core_clk_i, which models the dedicated RC source
   // and is never gated by sleep.
   logic [CW-1:0]        wdt_cnt_ff;
   logic [PS_STAGES-1:0] ps_cnt_ff;
   logic                 wdt_expire;
   logic                 base_tick;
   logic                 ps_tick;

   assign base_tick = (wdt_cnt_ff == CW'(WDT_CYCLES - 1));
   always_comb begin
      if (!prescaler_assign || rate == 3'h0)
         ps_tick = 1'b1;
      else
         ps_tick = (ps_cnt_ff & ((PS_STAGES'(1) << rate) - PS_STAGES'(1))) ==
                   ((PS_STAGES'(1) << rate) - PS_STAGES'(1));
   end
   assign wdt_expire = wdt_enabled && base_tick && ps_tick;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || !wdt_enabled) begin
         wdt_cnt_ff <= '0;
         ps_cnt_ff  <= '0;
      end else if (wdt_clear || master_clear_pin_n_rst || wdt_expire) begin
         wdt_cnt_ff <= '0;
         ps_cnt_ff  <= '0;
      end else if (base_tick) begin
         wdt_cnt_ff <= '0;
         ps_cnt_ff  <= prescaler_assign ? ps_cnt_ff + PS_STAGES'(1) : '0;
      end else begin
         wdt_cnt_ff <= wdt_cnt_ff + CW'(1);
      end
   end

   // ------------------------------------------------------------
   // Power state machine
   // ------------------------------------------------------------
   logic [OW-1:0] ost_cnt_ff;
   logic          irq_wake_ff;
   logic          irq_cause;

   // Direct RC wake leaves the same edge the cause is latched, so use the live one
   assign irq_cause = (state_ff == ST_SLEEP) ? (wake_irq && !wdt_expire) : irq_wake_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RUN: begin
            if (sleep_take)
               nxt_state = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (wdt_expire || wake_irq)
               nxt_state = is_rc_osc ? ST_RUN : ST_OST;
         end
         ST_OST: begin
            if (ost_cnt_ff == OW'(OST_CYCLES - 1))
               nxt_state = ST_RUN;
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || master_clear_pin_n_rst) begin
         state_ff <= ST_RUN;
      end else if (device_reset_o) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || state_ff != ST_OST)
         ost_cnt_ff <= '0;
      else
         ost_cnt_ff <= ost_cnt_ff + OW'(1);
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i)
         irq_wake_ff <= 1'b0;
      else if (state_ff == ST_SLEEP && nxt_state != ST_SLEEP)
         irq_wake_ff <= wake_irq && !wdt_expire;
      else if (state_ff == ST_RUN)
         irq_wake_ff <= 1'b0;
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         timeout_flag_n_ff   <= STATUS_RST[ST_TO];
         powerdown_flag_n_ff <= STATUS_RST[ST_PD];
      end else if (wdt_expire) begin
         timeout_flag_n_ff   <= 1'b0;
      end else if (sleep_take) begin
         timeout_flag_n_ff   <= 1'b1;
         powerdown_flag_n_ff <= 1'b0;
      end else if (watchdog_clear_instr_i) begin
         timeout_flag_n_ff   <= 1'b1;
         powerdown_flag_n_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Outputs to core and pins
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         device_reset_o    <= 1'b0;
         core_run_o        <= 1'b1;
         osc_drive_en_o    <= 1'b1;
         prefetch_o        <= 1'b0;
         fetch_addr_o      <= '0;
         vector_o          <= 1'b0;
         stack_push_o      <= 1'b0;
         push_pc_o         <= '0;
         periph_irq_gate_o <= 1'b1;
         master_clear_pin_n_drive_oe_n_o <= 1'b1;
      end else begin
         device_reset_o    <= master_clear_pin_n_rst || (wdt_expire && state_ff == ST_RUN);
         core_run_o        <= (nxt_state == ST_RUN) && !master_clear_pin_n_rst;
         osc_drive_en_o    <= (nxt_state != ST_SLEEP);
         prefetch_o        <= sleep_take;
         fetch_addr_o      <= pc_i + 16'h0001;
         vector_o          <= (state_ff != ST_RUN) && (nxt_state == ST_RUN) &&
                              irq_cause && global_irq_enable_i;
         stack_push_o      <= (state_ff != ST_RUN) && (nxt_state == ST_RUN) &&
                              irq_cause && global_irq_enable_i;
         push_pc_o         <= pc_i + 16'h0001;
         periph_irq_gate_o <= (nxt_state == ST_RUN);
         master_clear_pin_n_drive_oe_n_o <= 1'b1;
      end
   end

   // Pin states freeze while the core clock is stopped
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         io_out_o  <= 8'h00;
         io_oe_n_o <= 8'hff;
      end else if (state_ff == ST_RUN) begin
         io_out_o  <= io_out_i;
         io_oe_n_o <= io_oe_n_i;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_wdt_reset;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (wdt_expire && state_ff == ST_RUN && !master_clear_pin_n_rst) |=> device_reset_o;
   endproperty
   a_wdt_reset: assert property (p_wdt_reset) else $error("no reset on expiry");

   property p_wdt_wake;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (wdt_expire && state_ff == ST_SLEEP && !master_clear_pin_n_rst) |=> !device_reset_o && state_ff != ST_SLEEP;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("sleep expiry not a wake");

   property p_fuse_off;
      @(posedge core_clk_i) disable iff (!resetn_i)
      !wdt_enabled |-> !wdt_expire;
   endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("disabled watchdog expired");

   property p_to_clear;
      @(posedge core_clk_i) disable iff (!resetn_i)
      wdt_expire |=> !timeout_flag_n_ff;
   endproperty
   a_to_clear: assert property (p_to_clear) else $error("time-out flag not cleared");

   property p_sleep_flags;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (sleep_take && !wdt_expire) |=> timeout_flag_n_ff && !powerdown_flag_n_ff && wdt_cnt_ff == '0;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep side effects missing");

   property p_sleep_nop;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (sleep_instr_i && irq_pending && state_ff == ST_RUN && !master_clear_pin_n_rst) |=> state_ff == ST_RUN;
   endproperty
   a_sleep_nop: assert property (p_sleep_nop) else $error("sleep not a no-op");

   property p_master_clear_pin_n_pin;
      @(posedge core_clk_i) disable iff (!resetn_i)
      device_reset_o |-> master_clear_pin_n_drive_oe_n_o;
   endproperty
   a_master_clear_pin_n_pin: assert property (p_master_clear_pin_n_pin) else $error("master clear driven");

   property p_io_hold;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_ff == ST_SLEEP && $past(state_ff) == ST_SLEEP) |-> $stable(io_out_o) && $stable(io_oe_n_o);
   endproperty
   a_io_hold: assert property (p_io_hold) else $error("pins moved in sleep");

   property p_rc_wake;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_ff == ST_SLEEP && wake_irq && is_rc_osc && !master_clear_pin_n_rst) |=> state_ff == ST_RUN;
   endproperty
   a_rc_wake: assert property (p_rc_wake) else $error("RC wake delayed");

   property p_irq_vector;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (state_ff == ST_SLEEP && wake_irq && !wdt_expire && is_rc_osc && global_irq_enable_i && !master_clear_pin_n_rst)
      |=> vector_o && stack_push_o;
   endproperty
   a_irq_vector: assert property (p_irq_vector) else $error("no vector after irq wake");

   property p_vector_gie;
      @(posedge core_clk_i) disable iff (!resetn_i)
      vector_o |-> $past(global_irq_enable_i);
   endproperty
   a_vector_gie: assert property (p_vector_gie) else $error("vector without global enable");
endmodule : wdt_sleep_ctrl

/* verilog/wdt_sleep_pkg.sv */
// Package: constants and types for the watchdog and sleep controller
package wdt_sleep_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned WDT_PERIOD_US   = 18_000;
   localparam int unsigned WDT_BASE_CYC    = (WDT_PERIOD_US / 1000) * (CLK_HZ / 1000);
   localparam int unsigned OST_OSC_PERIODS = 1024;
   localparam int unsigned PS_STAGES       = 7;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [13:0] OPTION_IDX  = 14'h0081;
   localparam logic [13:0] CONFIG_IDX  = 14'h2007;
   localparam logic [13:0] STATUS_IDX  = 14'h0003;
   localparam logic [7:0]  OPTION_RST  = 8'hff;
   localparam logic [7:0]  STATUS_RST  = 8'h18;

   // Field positions
   localparam int unsigned OPT_PSA    = 3;
   localparam int unsigned OPT_PS_LO  = 0;
   localparam int unsigned CFG_WATCHDOG_ENABLE_FUSE   = 2;
   localparam int unsigned ST_PD      = 3;
   localparam int unsigned ST_TO      = 4;
   localparam logic [1:0]  OSC_RC     = 2'h3;

   localparam logic [15:0] VECTOR_ADDR = 16'h0004;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_SLEEP = 2'b01,
      ST_OST   = 2'b10
   } pm_state_t;

   typedef struct packed {
      logic ext_pin;
      logic port_change;
      logic ee_done;
      logic timer;
   } irq_vec_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [13:0] addr;
      logic [7:0]  wdata;
   } reg_req_t;
endpackage : wdt_sleep_pkg
